// ### testbench/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // serial lines
  output var logic sclk,
  output var logic cs_b,
  output var logic mosi,
  input  wire logic miso
);
  localparam int HALF = 80;

  initial begin
    sclk = 1'b1;
    cs_b = 1'b1;
    mosi = 1'b1;
  end

  // one full-duplex frame, clock idles high, msb first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_b = 1'b0;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = miso;
      #HALF;
    end
    cs_b = 1'b1;
    mosi = ~mosi;
    #(3 * HALF);
  endtask
endmodule
`default_nettype wire

// ### testbench/spi_page_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module spi_page_regs_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // serial port
  input wire logic        cs_b,
  input wire logic        miso_oe,
  input wire logic        busy,
  // configuration and strobes
  input wire logic [2:0]  active_page_select,
  input wire logic [15:0] network_identifier,
  input wire logic [15:0] gateway_tx_power,
  input wire logic [15:0] node_command_data,
  input wire logic        sys_cmd_strobe,
  input wire logic        node_wr_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_oe_idle: assert property (cs_b [*4] |=> !miso_oe)
    else $error("miso enable high while deselected");
  a_oe_active: assert property (!cs_b [*4] |=> miso_oe)
    else $error("miso enable low while selected");
  a_page_range: assert property (active_page_select <= 3'h6)
    else $error("page select beyond last page");
  a_cmd_page0: assert property (sys_cmd_strobe |->
    active_page_select == 3'h0)
    else $error("command strobe outside gateway page");
  a_strobe_pulse: assert property (sys_cmd_strobe |=>
    !sys_cmd_strobe)
    else $error("command strobe longer than one cycle");
  a_cfg_hold: assert property (cs_b [*8] |->
    $stable(network_identifier) && $stable(gateway_tx_power))
    else $error("configuration changed without a frame");
  a_busy_once: assert property (!busy |=> !busy)
    else $error("busy rose again after init");
  a_ready_busy: assert property (busy |-> !node_wr_ready)
    else $error("node port ready during init");
  a_reset_vals: assert property ($fell(busy) |->
    network_identifier == 16'h1234 && gateway_tx_power == 16'h0008
    && node_command_data == 16'h0000 && active_page_select == 3'h0)
    else $error("configuration not at reset values");
endmodule

bind spi_page_regs spi_page_regs_chk spi_page_regs_chk_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .miso_oe(miso_oe),
  .busy(busy), .active_page_select(active_page_select),
  .network_identifier(network_identifier),
  .gateway_tx_power(gateway_tx_power),
  .node_command_data(node_command_data),
  .sys_cmd_strobe(sys_cmd_strobe), .node_wr_ready(node_wr_ready)
);
`default_nettype wire

// ### testbench/spi_page_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value %s exp %h got %h", nm, exp, got); \
    end \
  end
module spi_page_regs_tb;
  localparam logic [15:0] PCODE = 16'h0c3c; // arbitrary identity value
  localparam logic [6:0] GA [9] = '{7'h04, 7'h06, 7'h0a, 7'h0c, 7'h0e,
                                    7'h1a, 7'h1c, 7'h24, 7'h2c};
  localparam logic [6:0] SA [6] = '{7'h12, 7'h14, 7'h16, 7'h18, 7'h20,
                                    7'h22};
  logic        ref_clk, rst_b, sclk, cs_b, mosi, miso, miso_oe, busy;
  logic [15:0] gw [9];
  logic [2:0]  active_page_select, node_wr_page;
  logic [15:0] network_identifier, gateway_tx_power, node_command_data;
  logic [15:0] radio_test_modes, output_pin_control;
  logic        sys_cmd_strobe, sys_cmd_upper, node_wr_valid, node_wr_ready;
  logic [7:0]  sys_cmd_data;
  logic [4:0]  node_wr_word;
  logic [15:0] node_wr_data;
  logic [8:0]  cmd_last;
  int          cmd_n = 0;
  int          n_errors = 0;
  int          cmp_count = 0;

  spi_page_regs #(.PRODUCT_CODE(PCODE)) spi_page_regs_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .busy(busy),
    .flash_count_g(gw[0]), .net_error_flags(gw[1]),
    .signal_strength_g(gw[2]), .temperature_g(gw[3]),
    .supply_voltage_g(gw[4]), .lot_code_one_g(gw[5]),
    .lot_code_two_g(gw[6]), .serial_number_g(gw[7]),
    .diag_flags_g(gw[8]), .active_page_select(active_page_select),
    .network_identifier(network_identifier),
    .gateway_tx_power(gateway_tx_power), .radio_test_modes(radio_test_modes),
    .node_command_data(node_command_data),
    .output_pin_control(output_pin_control),
    .sys_cmd_strobe(sys_cmd_strobe), .sys_cmd_upper(sys_cmd_upper),
    .sys_cmd_data(sys_cmd_data), .node_wr_valid(node_wr_valid),
    .node_wr_ready(node_wr_ready), .node_wr_page(node_wr_page),
    .node_wr_word(node_wr_word), .node_wr_data(node_wr_data)
  );

  spi_host_model spi_host_model_i (
    .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (sys_cmd_strobe === 1'b1) begin
      cmd_n++;
      cmd_last = {sys_cmd_upper, sys_cmd_data};
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] rx;
    spi_host_model_i.xfer({1'b1, a, d}, rx);
  endtask

  task automatic rd_chk(input string nm, input logic [6:0] a,
                        input logic [15:0] e);
    logic [15:0] v;
    spi_host_model_i.xfer({1'b0, a, 8'hc3}, v);
    spi_host_model_i.xfer(16'h0000, v);
    `CHK(nm, e, v)
  endtask

  task automatic node_wr(input logic [4:0] w, input logic [15:0] d);
    int i = 0;
    @(posedge ref_clk);
    #1;
    node_wr_valid = 1'b1;
    node_wr_page = 3'h3;
    node_wr_word = w;
    node_wr_data = d;
    while (node_wr_ready !== 1'b1 && i < 100) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    `CHK("node ready", 1'b1, node_wr_ready)
    @(posedge ref_clk);
    #1;
    node_wr_valid = 1'b0;
  endtask

  task automatic t_defaults();
    logic [15:0] v;
    spi_host_model_i.xfer(16'h02ff, v);
    spi_host_model_i.xfer(16'h0880, v);
    `CHK("net id", 16'h1234, v)
    spi_host_model_i.xfer(16'h1401, v);
    `CHK("tx power", 16'h0008, v)
    spi_host_model_i.xfer(16'h0000, v);
    `CHK("cmd data", 16'h0000, v)
    $display("test defaults done");
  endtask

  task automatic t_status();
    foreach (GA[k])
      rd_chk("gateway ro", GA[k], gw[k]);
    rd_chk("product", 7'h16, PCODE);
    rd_chk("reserved", 7'h18, 16'h0000);
    $display("test status done");
  endtask

  task automatic t_writes();
    wr(7'h02, 8'hab);
    wr(7'h03, 8'hcd);
    rd_chk("net id odd", 7'h03, 16'hcdab);
    `CHK("net id port", 16'hcdab, network_identifier)
    wr(7'h24, 8'h55);
    rd_chk("serial", 7'h24, gw[7]);
    wr(7'h14, 8'h06);
    `CHK("cmd port", 16'h0006, node_command_data)
    wr(7'h13, 8'h01);
    `CHK("cmd count", 1, cmd_n)
    `CHK("cmd byte", 9'h101, cmd_last)
    wr(7'h10, 8'h5a);
    wr(7'h2b, 8'h81);
    `CHK("test modes", 16'h005a, radio_test_modes)
    `CHK("pin ctrl", 16'h8108, output_pin_control)
    rd_chk("pin ctrl rd", 7'h2a, 16'h8108);
    rd_chk("cmd wo", 7'h12, 16'h0000);
    $display("test writes done");
  endtask

  task automatic t_pages();
    for (int p = 0; p < 8; p++) begin
      wr(7'h00, 8'(p));
      `CHK("page", (p > 6) ? 3'h6 : 3'(p), active_page_select)
    end
    wr(7'h00, 8'h03);
    rd_chk("avg01", 7'h0e, 16'h0108);
    rd_chk("avg23", 7'h10, 16'h0101);
    foreach (SA[k]) begin
      rd_chk("sensor default", SA[k], 16'h0000);
      wr(SA[k], 8'h3c);
      wr(SA[k] | 7'h01, {1'b0, SA[k]});
      rd_chk("sensor rw", SA[k], {1'b0, SA[k], 8'h3c});
    end
    node_wr(5'h03, 16'h5aa5);
    node_wr(5'h04, 16'h0ff0);
    node_wr(5'h05, 16'h1e2d);
    wr(7'h06, 8'h00);
    rd_chk("x buf", 7'h06, 16'h5aa5);
    rd_chk("y buf", 7'h08, 16'h0ff0);
    rd_chk("temp", 7'h0a, 16'h1e2d);
    wr(7'h00, 8'h02);
    rd_chk("other page", 7'h12, 16'h0000);
    $display("test pages done");
  endtask

  initial begin
    rst_b = 1'b0;
    node_wr_valid = 1'b0;
    node_wr_page = 3'h1;
    node_wr_word = 5'h00;
    node_wr_data = 16'h0000;
    for (int k = 0; k < 9; k++)
      gw[k] = 16'h9c30 ^ (16'h0111 * 16'(k));
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge ref_clk);
    #1;
    `CHK("busy", 1'b0, busy)
    t_defaults();
    t_status();
    t_writes();
    t_pages();
    stop_test();
  end

  initial begin
    #800000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

// ### verilog/page_reg_mem.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// simple dual-port word store with byte enables, registered read
// ----------------------------------------------------------------------
module page_reg_mem #(
  parameter DW    = 16,
  parameter AW    = 8,
  parameter DEPTH = 192
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_b,
  // write port
  input  wire          wr_en,
  input  wire [1:0]    wr_be,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  // read port
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      if (wr_be[0])
        mem[wr_addr][DW/2-1:0] <= wr_data[DW/2-1:0];
      if (wr_be[1])
        mem[wr_addr][DW-1:DW/2] <= wr_data[DW-1:DW/2];
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      rd_data <= {DW{1'b0}};
    else if (rd_en)
      rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ### verilog/spi_page_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "spi_page_regs_defs.vh"

// Summary of operation
// - a read takes two 16-bit frames: request, then returned value
// - low eight data bits of a read request frame are ignored
// - register addressed in previous frame shifts out in the next
// - the answering frame may itself carry the next read request
// - gateway page: network identifier at 0x02, resets to 0x1234
// - gateway page: transmit power at 0x08, resets to 0x0008
// - gateway page: node command data at 0x14, resets to 0x0000
// - gateway page: read-only serial number at 0x24
// - sensor pages: read-only x and y buffers at 0x06 and 0x08
// - sensor pages: buffer index at 0x12, read/write, reset 0x0000
// - sensor pages: record index at 0x14, read/write, reset 0x0000
// - sensor pages: averaging controls 0x0e=0x0108, 0x10=0x0101
// - sensor pages: x and y scale correction at 0x16 and 0x18
// - sensor pages: read-only capture temperature at 0x0a
// - sensor pages: alarm band limits 0x20 and 0x22, reset 0x0000
// - writing 0 to 6 at address 0x00 selects the active page
// - sample on rising clock, change on falling, msb first, 16 bits
// - each register has upper and lower byte address, byte writes
module spi_page_regs #(
  parameter [15:0] PRODUCT_CODE = 16'h0a5a  // arbitrary identity value
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // serial port
  input  wire        sclk,
  input  wire        cs_b,
  input  wire        mosi,
  output reg         miso,
  output reg         miso_oe,
  output wire        busy,
  // gateway status from radio logic
  input  wire [15:0] flash_count_g,
  input  wire [15:0] net_error_flags,
  input  wire [15:0] signal_strength_g,
  input  wire [15:0] temperature_g,
  input  wire [15:0] supply_voltage_g,
  input  wire [15:0] lot_code_one_g,
  input  wire [15:0] lot_code_two_g,
  input  wire [15:0] serial_number_g,
  input  wire [15:0] diag_flags_g,
  // gateway configuration
  output reg  [2:0]  active_page_select,
  output reg  [15:0] network_identifier,
  output reg  [15:0] gateway_tx_power,
  output reg  [15:0] radio_test_modes,
  output reg  [15:0] node_command_data,
  output reg  [15:0] output_pin_control,
  // system command strobe
  output reg         sys_cmd_strobe,
  output reg         sys_cmd_upper,
  output reg  [7:0]  sys_cmd_data,
  // node data updates from radio logic
  input  wire        node_wr_valid,
  output wire        node_wr_ready,
  input  wire [2:0]  node_wr_page,
  input  wire [4:0]  node_wr_word,
  input  wire [15:0] node_wr_data
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function [15:0] merge_byte;
    input [15:0] old;
    input [7:0]  data;
    input        upper;
    begin
      merge_byte = upper ? {data, old[7:0]} : {old[15:8], data};
    end
  endfunction

  function sens_writable;
    input [6:0] key;
    begin
      case (key)
        `OFF_FFT_AVG01, `OFF_FFT_AVG23, `OFF_BUF_INDEX, `OFF_REC_INDEX,
        `OFF_X_SCALE, `OFF_Y_SCALE, `OFF_REC_CTRL_A, `OFF_REC_CTRL_B,
        `OFF_BAND_LOW, `OFF_BAND_HIGH, 7'h24, 7'h26, `OFF_SENS_LAST:
          sens_writable = 1'b1;
        default:
          sens_writable = 1'b0;
      endcase
    end
  endfunction

  function [15:0] sens_default;
    input [4:0] word;
    begin
      case ({1'b0, word, 1'b0})
        `OFF_FFT_AVG01:  sens_default = `RST_FFT_AVG01;
        `OFF_FFT_AVG23:  sens_default = `RST_FFT_AVG23;
        `OFF_REC_CTRL_A: sens_default = `RST_REC_CTRL_A;
        `OFF_REC_CTRL_B: sens_default = `RST_REC_CTRL_B;
        default:         sens_default = `RST_ZERO;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // pin synchronisers and edge detect
  // --------------------------------------------------------------------
  reg [2:0] sclk_sync_r;
  reg [1:0] cs_sync_r;
  reg [1:0] din_sync_r;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_r <= 3'h7;
      cs_sync_r   <= 2'h3;
      din_sync_r  <= 2'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], sclk};
      cs_sync_r   <= {cs_sync_r[0], cs_b};
      din_sync_r  <= {din_sync_r[0], mosi};
    end
  end

  wire sel      = ~cs_sync_r[1];
  wire din_s    = din_sync_r[1];
  wire sclk_ris = sel & sclk_sync_r[1] & ~sclk_sync_r[2];
  wire sclk_fal = sel & ~sclk_sync_r[1] & sclk_sync_r[2];

  // --------------------------------------------------------------------
  // frame receiver
  // --------------------------------------------------------------------
  reg [3:0]  bit_cnt_r;
  reg [14:0] rx_shift_r;
  reg        frame_done_r;
  reg [15:0] frame_word_r;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r    <= 4'h0;
      rx_shift_r   <= 15'h0000;
      frame_done_r <= 1'b0;
      frame_word_r <= 16'h0000;
    end else begin
      frame_done_r <= 1'b0;
      if (!sel) begin
        bit_cnt_r <= 4'h0;
      end else if (sclk_ris) begin
        rx_shift_r <= {rx_shift_r[13:0], din_s};
        bit_cnt_r  <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == `FRAME_LAST_BIT) begin
          frame_done_r <= 1'b1;
          frame_word_r <= {rx_shift_r, din_s};
        end
      end
    end
  end

  wire       fr_write = frame_word_r[`BIT_WRITE];
  wire [6:0] fr_key   = {frame_word_r[`ADDR_MSB:`ADDR_LSB+1], 1'b0};
  wire       fr_upper = frame_word_r[`ADDR_LSB];
  wire [7:0] fr_data  = frame_word_r[7:0];

  // --------------------------------------------------------------------
  // control state machine
  // --------------------------------------------------------------------
  localparam [2:0] ST_INIT   = 3'b001;
  localparam [2:0] ST_IDLE   = 3'b010;
  localparam [2:0] ST_RDWAIT = 3'b100;

  reg [2:0]          state_r;
  reg [2:0]          state_nxt;
  reg [`SENS_AW-1:0] init_cnt_r;
  reg [6:0]          rd_key_r;
  reg [2:0]          rd_page_r;

  wire init_last = (init_cnt_r == `SENS_INIT_LAST);
  wire idle      = (state_r == ST_IDLE);
  wire rd_req    = idle & frame_done_r & ~fr_write;
  wire wr_req    = idle & frame_done_r & fr_write;

  assign busy          = (state_r == ST_INIT);
  assign node_wr_ready = idle & ~frame_done_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT:   if (init_last) state_nxt = ST_IDLE;
      ST_IDLE:   if (rd_req) state_nxt = ST_RDWAIT;
      ST_RDWAIT: state_nxt = ST_IDLE;
      default:   state_nxt = ST_INIT;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= ST_INIT;
      init_cnt_r <= {`SENS_AW{1'b0}};
      rd_key_r   <= 7'h00;
      rd_page_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (busy)
        init_cnt_r <= init_cnt_r + 1'b1;
      if (rd_req) begin
        rd_key_r  <= fr_key;
        rd_page_r <= active_page_select;
      end
    end
  end

  // --------------------------------------------------------------------
  // sensor page store
  // --------------------------------------------------------------------
  wire               sens_page = (active_page_select != 3'h0);
  wire [2:0]         pg_idx    = active_page_select - 3'h1;
  wire [2:0]         node_idx  = node_wr_page - 3'h1;
  wire               spi_sens_we = wr_req & sens_page & sens_writable(fr_key);
  wire               node_take = node_wr_valid & node_wr_ready;
  reg                mem_we;
  reg  [1:0]         mem_be;
  reg  [`SENS_AW-1:0] mem_waddr;
  reg  [15:0]        mem_wdata;
  wire [15:0]        mem_rdata;

  always @* begin
    mem_we    = 1'b0;
    mem_be    = 2'b11;
    mem_waddr = init_cnt_r;
    mem_wdata = sens_default(init_cnt_r[4:0]);
    if (busy) begin
      mem_we = 1'b1;
    end else if (spi_sens_we) begin
      mem_we    = 1'b1;
      mem_be    = {fr_upper, ~fr_upper};
      mem_waddr = {pg_idx, fr_key[5:1]};
      mem_wdata = {fr_data, fr_data};
    end else if (node_take) begin
      mem_we    = 1'b1;
      mem_waddr = {node_idx, node_wr_word};
      mem_wdata = node_wr_data;
    end
  end

  page_reg_mem #(
    .DW    (16),
    .AW    (`SENS_AW),
    .DEPTH (`SENS_DEPTH)
  ) page_reg_mem_i (
    .clk     (ref_clk),
    .rst_b   (rst_b),
    .wr_en   (mem_we),
    .wr_be   (mem_be),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_en   (rd_req),
    .rd_addr ({pg_idx, fr_key[5:1]}),
    .rd_data (mem_rdata)
  );

  // --------------------------------------------------------------------
  // gateway page writes
  // --------------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_page_select <= 3'h0;
      network_identifier <= `RST_NET_ID;
      gateway_tx_power   <= `RST_TX_PWR_G;
      radio_test_modes   <= `RST_ZERO;
      node_command_data  <= `RST_ZERO;
      output_pin_control <= `RST_PIN_CTRL;
      sys_cmd_strobe     <= 1'b0;
      sys_cmd_upper      <= 1'b0;
      sys_cmd_data       <= 8'h00;
    end else begin
      sys_cmd_strobe <= 1'b0;
      if (wr_req && fr_key == `OFF_PAGE_SEL) begin
        if (!fr_upper && fr_data <= {5'h00, `PAGE_MAX})
          active_page_select <= fr_data[2:0];
      end else if (wr_req && !sens_page) begin
        case (fr_key)
          `OFF_NET_ID:
            network_identifier <=
              merge_byte(network_identifier, fr_data, fr_upper);
          `OFF_TX_PWR_G:
            gateway_tx_power <=
              merge_byte(gateway_tx_power, fr_data, fr_upper);
          `OFF_RADIO_TEST:
            radio_test_modes <=
              merge_byte(radio_test_modes, fr_data, fr_upper);
          `OFF_NODE_CMD:
            node_command_data <=
              merge_byte(node_command_data, fr_data, fr_upper);
          `OFF_PIN_CTRL:
            output_pin_control <=
              merge_byte(output_pin_control, fr_data, fr_upper);
          `OFF_SYS_CMD: begin
            sys_cmd_strobe <= 1'b1;
            sys_cmd_upper  <= fr_upper;
            sys_cmd_data   <= fr_data;
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // read value selection
  // --------------------------------------------------------------------
  reg [15:0] gw_val;
  reg [15:0] rd_val;

  always @* begin
    case (rd_key_r)
      `OFF_PAGE_SEL:    gw_val = {13'h0000, active_page_select};
      `OFF_NET_ID:      gw_val = network_identifier;
      `OFF_FLASH_WR_G:  gw_val = flash_count_g;
      `OFF_NET_ERR:     gw_val = net_error_flags;
      `OFF_TX_PWR_G:    gw_val = gateway_tx_power;
      `OFF_SIG_STR_G:   gw_val = signal_strength_g;
      `OFF_TEMP_G:      gw_val = temperature_g;
      `OFF_SUPPLY_G:    gw_val = supply_voltage_g;
      `OFF_RADIO_TEST:  gw_val = radio_test_modes;
      `OFF_NODE_CMD:    gw_val = node_command_data;
      `OFF_PROD_CODE:   gw_val = PRODUCT_CODE;
      `OFF_LOT_ONE_G:   gw_val = lot_code_one_g;
      `OFF_LOT_TWO_G:   gw_val = lot_code_two_g;
      `OFF_SERIAL_G:    gw_val = serial_number_g;
      `OFF_PIN_CTRL:    gw_val = output_pin_control;
      `OFF_DIAG_G:      gw_val = diag_flags_g;
      default:          gw_val = `RST_ZERO;
    endcase
  end

  always @* begin
    if (rd_key_r == `OFF_PAGE_SEL)
      rd_val = {13'h0000, active_page_select};
    else if (rd_page_r == 3'h0)
      rd_val = gw_val;
    else if (rd_key_r > `OFF_SENS_LAST || rd_key_r == `OFF_RSVD_S)
      rd_val = `RST_ZERO;
    else
      rd_val = mem_rdata;
  end

  // --------------------------------------------------------------------
  // output shifter
  // --------------------------------------------------------------------
  reg [15:0] tx_shift_r;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_r <= 16'h0000;
      miso       <= 1'b0;
      miso_oe    <= 1'b0;
    end else begin
      if (state_r == ST_RDWAIT)
        tx_shift_r <= rd_val;
      else if (wr_req)
        tx_shift_r <= 16'h0000;
      else if (sclk_fal && bit_cnt_r != 4'h0)
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      miso    <= tx_shift_r[15];
      miso_oe <= sel;
    end
  end

endmodule

`default_nettype wire

// ### verilog/spi_page_regs_defs.vh
`ifndef SPI_PAGE_REGS_DEFS_VH
`define SPI_PAGE_REGS_DEFS_VH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define FRAME_BITS       16
`define FRAME_LAST_BIT   4'hf
`define BIT_WRITE        15
`define ADDR_MSB         14
`define ADDR_LSB         8
`define PAGE_MAX         3'h6

// ----------------------------------------------------------------------
// byte offsets, gateway page
// ----------------------------------------------------------------------
`define OFF_PAGE_SEL     7'h00
`define OFF_NET_ID       7'h02
`define OFF_FLASH_WR_G   7'h04
`define OFF_NET_ERR      7'h06
`define OFF_TX_PWR_G     7'h08
`define OFF_SIG_STR_G    7'h0a
`define OFF_TEMP_G       7'h0c
`define OFF_SUPPLY_G     7'h0e
`define OFF_RADIO_TEST   7'h10
`define OFF_SYS_CMD      7'h12
`define OFF_NODE_CMD     7'h14
`define OFF_PROD_CODE    7'h16
`define OFF_LOT_ONE_G    7'h1a
`define OFF_LOT_TWO_G    7'h1c
`define OFF_SERIAL_G     7'h24
`define OFF_PIN_CTRL     7'h2a
`define OFF_DIAG_G       7'h2c

// ----------------------------------------------------------------------
// byte offsets, sensor pages
// ----------------------------------------------------------------------
`define OFF_X_ACCEL      7'h06
`define OFF_Y_ACCEL      7'h08
`define OFF_TEMP_S       7'h0a
`define OFF_FFT_AVG01    7'h0e
`define OFF_FFT_AVG23    7'h10
`define OFF_BUF_INDEX    7'h12
`define OFF_REC_INDEX    7'h14
`define OFF_X_SCALE      7'h16
`define OFF_Y_SCALE      7'h18
`define OFF_REC_CTRL_A   7'h1a
`define OFF_REC_CTRL_B   7'h1c
`define OFF_RSVD_S       7'h1e
`define OFF_BAND_LOW     7'h20
`define OFF_BAND_HIGH    7'h22
`define OFF_SENS_LAST    7'h28

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_ZERO         16'h0000
`define RST_NET_ID       16'h1234
`define RST_TX_PWR_G     16'h0008
`define RST_PIN_CTRL     16'h0008
`define RST_FFT_AVG01    16'h0108
`define RST_FFT_AVG23    16'h0101
`define RST_REC_CTRL_A   16'h1102
`define RST_REC_CTRL_B   16'h00ff

// ----------------------------------------------------------------------
// sensor page store
// ----------------------------------------------------------------------
`define SENS_WORDS       32
`define SENS_DEPTH       192
`define SENS_AW          8
`define SENS_INIT_LAST   8'hbf

`endif
